// file: core/sar_ctl.sv
// Control and host interface of a self-calibrating 13-bit SAR converter.
// Function
// - Select low enables write, read, sample/hold.
// - Reading drives bus and releases interrupt high.
// - Write rising edge starts internally timed conversion.
// - Write start: acquisition ends 6 to 7 periods.
// - Aligned write edge: acquisition ends at 6.5.
// - Sample/hold low opens, rising edge converts.
// - Calibration request low resets and calibrates.
// - Offset-null low at write start inserts 26-period cycle first.
// - End-of-conversion low during conversion or calibration.
// - Interrupt low when result is latched.
// - Read or new start returns interrupt high.
// - Two byte reads, upper first, sign extended.
// - Calibration holds end-of-conversion low 1399 periods.
// - Sign bit resolved before magnitude bits.
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`include "sar_ctl_consts.svh"
module sar_ctl #(
	parameter int HALF_CYC = `CONV_HALF_CYC,
	parameter int CAL_HALVES = `CAL_HALVES
) (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic cs_n_i,
	input wire logic wr_n_i,
	input wire logic rd_n_i,
	input wire logic sh_n_i,
	input wire logic cal_n_i,
	input wire logic offset_null_request_n_i,
	input wire sar_ctl_pkg::sample_t sample_i,
	output logic end_of_conv_o,
	output logic result_ready_n_o,
	output logic [7:0] result_byte_bus_o,
	output logic result_byte_bus_oe_o,
	input wire logic [`ADDR_W-1:0] reg_addr_i,
	input wire logic [`DATA_W-1:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [`DATA_W-1:0] reg_rdata_o,
	output logic irq_o
);
	import sar_ctl_pkg::*;

	localparam logic [11:0] ACQ_LAST = 12'(`ACQ_PERIODS_X2 - 1);
	localparam logic [11:0] NULL_LAST = 12'(`NULL_HALVES - 1);
	localparam logic [11:0] CAL_LAST = 12'(CAL_HALVES - 1);

	function automatic logic [7:0] pick_byte(input sample_t r,
		input logic low);
		pick_byte = low ? r[7:0] : {{4{r[12]}}, r[11:8]};
	endfunction

	state_t state_reg, state_next;
	logic [11:0] cnt_reg;
	logic wr_last_reg, sh_last_reg, cal_last_reg, rd_last_reg;
	logic ptr_reg;
	sample_t result_reg, offset_reg;
	logic [`EV_W-1:0] status_reg, enable_reg;
	logic half_tick;
	logic sar_done_raw;
	// A sequencer left running by a restart or calibration must not report.
	wire sar_done = sar_done_raw && (state_reg == ST_CONV);
	sample_t sar_result;

	// Write, read and sample/hold strobes only count while select is low; calibration request does not need select.
	wire sel = !cs_n_i;
	wire wr_rise = sel && wr_n_i && !wr_last_reg;
	wire sh_fall = sel && !sh_n_i && sh_last_reg;
	wire sh_rise = sel && sh_n_i && !sh_last_reg;
	wire rd_active = sel && !rd_n_i;
	wire rd_end = rd_last_reg && !rd_active;
	wire cal_fall = !cal_n_i && cal_last_reg;
	wire in_cal = (state_reg == ST_CAL);
	wire cal_go = cal_fall && !in_cal;
	wire conv_ok = !in_cal && !cal_go;
	wire wr_go = conv_ok && wr_rise;
	wire sh_go = conv_ok && !wr_rise && sh_fall;
	wire sh_hold = conv_ok && sh_rise && (state_reg == ST_ACQ_SH);
	wire start = cal_go || wr_go || sh_go;
	wire cnt_step = half_tick && (state_reg == ST_NULL ||
		state_reg == ST_ACQ_WR || in_cal);
	wire enter_conv = (state_next == ST_CONV) && (state_reg != ST_CONV);
	wire cal_end = in_cal && half_tick && (cnt_reg == CAL_LAST);
	wire [`EV_W-1:0] events = {cal_end, sar_done};
	wire [`EV_W-1:0] clr = (reg_we_i && reg_addr_i == `REG_CLEAR) ?
		reg_wdata_i[`EV_W-1:0] : '0;
	wire [`EV_W-1:0] status_next = (status_reg & ~clr) | events;
	wire [`DATA_W-1:0] state_word = {2'h0, ptr_reg, 2'h0,
		3'(state_reg)};
	wire [`DATA_W-1:0] rd_mux =
		(reg_addr_i == `REG_STATUS) ? `DATA_W'(status_reg) :
		(reg_addr_i == `REG_ENABLE) ? `DATA_W'(enable_reg) :
		(reg_addr_i == `REG_STATE) ? state_word : '0;

	half_tick_div #(
		.HALF_CYC(HALF_CYC)
	) u_div (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.tick_o(half_tick)
	);

	logic period_phase_reg;
	wire period_tick = half_tick && period_phase_reg;

	sar_engine u_sar (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.start_i(enter_conv),
		.step_i(period_tick),
		.held_i(sample_t'(sample_i - offset_reg)),
		.done_o(sar_done_raw),
		.result_o(sar_result)
	);

	always_comb
	begin
		state_next = state_reg;
		if (cal_go)
			state_next = ST_CAL;
		else if (wr_go)
			state_next = offset_null_request_n_i ? ST_ACQ_WR : ST_NULL;
		else if (sh_go)
			state_next = ST_ACQ_SH;
		else if (sh_hold)
			state_next = ST_CONV;
		else
		begin
			case (state_reg)
				ST_NULL:
					if (cnt_step && cnt_reg == NULL_LAST)
						state_next = ST_ACQ_WR;
				ST_ACQ_WR:
					if (cnt_step && cnt_reg == ACQ_LAST)
						state_next = ST_CONV;
				ST_CONV:
					if (sar_done)
						state_next = ST_IDLE;
				ST_CAL:
					if (cal_end)
						state_next = ST_IDLE;
				default:
					state_next = state_reg;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state_reg <= ST_IDLE;
			cnt_reg <= 12'h000;
			period_phase_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			if (half_tick)
				period_phase_reg <= !period_phase_reg;
			if (state_next != state_reg || start)
				cnt_reg <= 12'h000;
			else if (cnt_step)
				cnt_reg <= cnt_reg + 12'h001;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			wr_last_reg <= 1'b1;
			sh_last_reg <= 1'b1;
			cal_last_reg <= 1'b1;
			rd_last_reg <= 1'b0;
		end
		else
		begin
			wr_last_reg <= wr_n_i;
			sh_last_reg <= sh_n_i;
			cal_last_reg <= cal_n_i;
			rd_last_reg <= rd_active;
		end
	end

	// The calibration captures the null offset applied to later samples.
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			offset_reg <= 13'h0000;
			result_reg <= 13'h0000;
			ptr_reg <= 1'b0;
		end
		else
		begin
			if (cal_go)
				offset_reg <= sample_i;
			if (sar_done)
				result_reg <= sar_result;
			if (start)
				ptr_reg <= 1'b0;
			else if (rd_end)
				ptr_reg <= !ptr_reg;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			end_of_conv_o <= 1'b1;
			result_ready_n_o <= 1'b1;
			result_byte_bus_o <= 8'h00;
			result_byte_bus_oe_o <= 1'b0;
		end
		else
		begin
			end_of_conv_o <= !(state_next == ST_CONV ||
				state_next == ST_CAL);
			if (sar_done)
				result_ready_n_o <= 1'b0;
			else if (rd_active || start)
				result_ready_n_o <= 1'b1;
			result_byte_bus_o <= pick_byte(result_reg, ptr_reg);
			result_byte_bus_oe_o <= rd_active;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			status_reg <= '0;
			enable_reg <= `ENABLE_RST;
			reg_rdata_o <= '0;
			irq_o <= 1'b0;
		end
		else
		begin
			status_reg <= status_next;
			if (reg_we_i && reg_addr_i == `REG_ENABLE)
				enable_reg <= reg_wdata_i[`EV_W-1:0];
			reg_rdata_o <= reg_re_i ? rd_mux : '0;
			irq_o <= |(status_next & enable_reg);
		end
	end

	// Cycles spent in write-timed acquisition, for checking only.
	logic [7:0] acq_len_reg;
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			acq_len_reg <= 8'h00;
		else if (wr_go || (state_next == ST_ACQ_WR &&
			state_reg != ST_ACQ_WR))
			acq_len_reg <= 8'h01;
		else if (state_reg == ST_ACQ_WR)
			acq_len_reg <= acq_len_reg + 8'h01;
	end
	localparam int ACQ_MIN = 12 * HALF_CYC;
	localparam int ACQ_MAX = 14 * HALF_CYC;

	// Set once a read has ended since the last start, for checking only.
	logic read_seen_reg;
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			read_seen_reg <= 1'b0;
		else if (start)
			read_seen_reg <= 1'b0;
		else if (rd_end)
			read_seen_reg <= 1'b1;
	end

	property p_select_gate;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		cs_n_i && state_reg == ST_IDLE && !cal_fall |=> state_reg == ST_IDLE;
	endproperty
	a_select_gate: assert property (p_select_gate)
		else $error("strobe acted without select");

	property p_read_drive;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		rd_active && !sar_done |=> result_byte_bus_oe_o && result_ready_n_o;
	endproperty
	a_read_drive: assert property (p_read_drive)
		else $error("read did not drive bus or release interrupt");

	property p_wr_start;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		wr_go && offset_null_request_n_i |=> state_reg == ST_ACQ_WR;
	endproperty
	a_wr_start: assert property (p_wr_start)
		else $error("write edge did not open acquisition");

	property p_acq_len;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		state_reg == ST_ACQ_WR && state_next == ST_CONV |->
			acq_len_reg >= 8'(ACQ_MIN) && acq_len_reg <= 8'(ACQ_MAX);
	endproperty
	a_acq_len: assert property (p_acq_len)
		else $error("acquisition length outside 6 to 7 periods");

	property p_sh_hold;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		sh_hold && !wr_go |=> state_reg == ST_CONV && !end_of_conv_o;
	endproperty
	a_sh_hold: assert property (p_sh_hold)
		else $error("sample/hold rise did not start conversion");

	sequence s_cal_entry;
		cal_go ##1 (state_reg == ST_CAL && !end_of_conv_o);
	endsequence
	property p_cal_start;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		cal_go |-> s_cal_entry;
	endproperty
	a_cal_start: assert property (p_cal_start)
		else $error("calibration request not acted on");

	property p_null;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		wr_go && !offset_null_request_n_i |=> state_reg == ST_NULL;
	endproperty
	a_null: assert property (p_null)
		else $error("offset-null cycle not inserted");

	property p_cal_hold;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		in_cal && !cal_end |=> !end_of_conv_o && in_cal;
	endproperty
	a_cal_hold: assert property (p_cal_hold)
		else $error("end-of-conversion rose during calibration");

	property p_int_done;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		sar_done |=> !result_ready_n_o && end_of_conv_o;
	endproperty
	a_int_done: assert property (p_int_done)
		else $error("interrupt not raised at end of conversion");

	property p_int_clear;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		start && !sar_done |=> result_ready_n_o;
	endproperty
	a_int_clear: assert property (p_int_clear)
		else $error("start did not release interrupt");

	property p_upper_first;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		rd_active && !read_seen_reg && !start && !sar_done |=>
			result_byte_bus_o == {{4{result_reg[12]}}, result_reg[11:8]};
	endproperty
	a_upper_first: assert property (p_upper_first)
		else $error("first read after start not upper byte");
endmodule

// file: core/sar_ctl_consts.svh
// Offsets, field positions, reset values and timing counts of the converter.
`ifndef SAR_CTL_CONSTS_SVH
`define SAR_CTL_CONSTS_SVH

`define CLK_SYS_NS 100
`define CONV_HALF_NS 200
`define CONV_HALF_CYC (`CONV_HALF_NS / `CLK_SYS_NS)

// Interval lengths in conversion periods, or half periods where doubled.
`define ACQ_PERIODS_X2 13
`define NULL_PERIODS 26
`define NULL_HALVES (`NULL_PERIODS * 2)
`define CAL_PERIODS 1399
`define CAL_HALVES (`CAL_PERIODS * 2)
`define SAR_STEPS 13

`define ADDR_W 4
`define DATA_W 8
`define REG_STATUS 4'h0
`define REG_ENABLE 4'h4
`define REG_CLEAR 4'h8
`define REG_STATE 4'hC
`define EV_CONV 0
`define EV_CAL 1
`define EV_W 2
`define ENABLE_RST 2'h0

`endif

// file: core/sar_ctl_pkg.sv
// Types shared by the converter control logic.
package sar_ctl_pkg;
	typedef logic [12:0] sample_t;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_NULL,
		ST_ACQ_WR,
		ST_ACQ_SH,
		ST_CONV,
		ST_CAL
	} state_t;
endpackage

// file: core/half_tick_div.sv
// Divider giving a one-cycle pulse every half conversion clock period.
`timescale 1ns/1ns
module half_tick_div #(
	parameter int HALF_CYC = 2
) (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	output logic tick_o
);
	localparam logic [7:0] LAST = 8'(HALF_CYC - 1);
	logic [7:0] cnt_reg;
	wire wrap = (cnt_reg == LAST);

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			cnt_reg <= 8'h00;
			tick_o <= 1'b0;
		end
		else
		begin
			cnt_reg <= wrap ? 8'h00 : cnt_reg + 8'h01;
			tick_o <= wrap;
		end
	end
endmodule

// file: core/sar_engine.sv
// Successive approximation sequencer: sign first, then magnitude MSB to LSB.
`timescale 1ns/1ns
`include "sar_ctl_consts.svh"
module sar_engine (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic start_i,
	input wire logic step_i,
	input wire sar_ctl_pkg::sample_t held_i,
	output logic done_o,
	output sar_ctl_pkg::sample_t result_o
);
	import sar_ctl_pkg::*;
	localparam logic [3:0] LAST = 4'(`SAR_STEPS - 1);
	sample_t held_reg;
	logic [3:0] step_reg;
	logic busy_reg;
	wire [3:0] bit_idx = 4'hC - step_reg;
	wire [11:0] mask = 12'h001 << bit_idx;
	wire [11:0] trial = result_o[11:0] | mask;
	wire keep = (trial <= held_reg[11:0]);
	wire act = busy_reg && step_i;

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			held_reg <= 13'h0000;
			step_reg <= 4'h0;
			busy_reg <= 1'b0;
			done_o <= 1'b0;
			result_o <= 13'h0000;
		end
		else
		begin
			done_o <= act && (step_reg == LAST);
			if (start_i)
			begin
				held_reg <= held_i;
				step_reg <= 4'h0;
				busy_reg <= 1'b1;
				result_o <= 13'h0000;
			end
			else if (act)
			begin
				step_reg <= step_reg + 4'h1;
				busy_reg <= (step_reg != LAST);
				if (step_reg == 4'h0)
					result_o <= {held_reg[12], 12'h000};
				else if (keep)
					result_o[11:0] <= trial;
			end
		end
	end

	property p_sign_first;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		act && step_reg == 4'h0 |=> result_o == {held_reg[12], 12'h000};
	endproperty
	a_sign_first: assert property (p_sign_first)
		else $error("sign bit not resolved first");
endmodule

// file: tb/host_model.sv
// Host bus model driving the converter's select and strobe pins.
`timescale 1ns/1ns
module host_model (
	input wire logic clk_sys_i,
	input wire logic end_of_conv_i,
	input wire logic result_ready_n_i,
	input wire logic [7:0] result_byte_bus_i,
	input wire logic result_byte_bus_oe_i,
	output logic cs_n_o,
	output logic wr_n_o,
	output logic rd_n_o,
	output logic sh_n_o,
	output logic cal_n_o,
	output logic offset_null_request_n_o
);
	initial
	begin
		cs_n_o = 1'b1;
		wr_n_o = 1'b1;
		rd_n_o = 1'b1;
		sh_n_o = 1'b1;
		cal_n_o = 1'b1;
		offset_null_request_n_o = 1'b1;
	end
	task automatic calibrate();
		@(posedge clk_sys_i);
		cal_n_o <= 1'b0;
		@(posedge clk_sys_i);
		cal_n_o <= 1'b1;
	endtask
	// A start is only issued once the previous conversion has ended.
	task automatic start_write(input logic nl, input logic cs);
		wait (end_of_conv_i === 1'b1);
		@(posedge clk_sys_i);
		cs_n_o <= cs;
		wr_n_o <= 1'b0;
		offset_null_request_n_o <= nl;
		@(posedge clk_sys_i);
		wr_n_o <= 1'b1;
		@(posedge clk_sys_i);
		cs_n_o <= 1'b1;
	endtask
	task automatic start_sh();
		wait (end_of_conv_i === 1'b1);
		@(posedge clk_sys_i);
		cs_n_o <= 1'b0;
		sh_n_o <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		sh_n_o <= 1'b1;
		@(posedge clk_sys_i);
		cs_n_o <= 1'b1;
	endtask
	task automatic read_byte(input logic cs, output logic [7:0] b,
		output logic oe, output logic rdy);
		@(posedge clk_sys_i);
		cs_n_o <= cs;
		rd_n_o <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		#1 b = result_byte_bus_i;
		oe = result_byte_bus_oe_i;
		rdy = result_ready_n_i;
		@(posedge clk_sys_i);
		cs_n_o <= 1'b1;
		rd_n_o <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
	endtask
endmodule

// file: tb/sar_ctl_test.sv
// Self-checking bench of the converter control block.
`timescale 1ns/1ns
`include "sar_ctl_consts.svh"
`define CHK(nm, e, a) \
	begin \
		checks++; \
		if ((a) !== (e)) \
		begin \
			n_mismatch++; \
			$display("mismatch %s exp %h got %h", nm, e, a); \
		end \
	end
module sar_ctl_test;
	import sar_ctl_pkg::*;
	localparam int CALC = 80;
	logic clk_sys_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic cs_n, wr_n, rd_n, sh_n, cal_n, null_n;
	sample_t sample = '0;
	logic eoc, rdy_n, oe, irq;
	logic [7:0] bus;
	logic [`DATA_W-1:0] rdata;
	logic [`ADDR_W-1:0] addr = '0;
	logic [`DATA_W-1:0] wdata = '0;
	logic we = 1'b0;
	logic re = 1'b0;
	int n_mismatch = 0;
	int checks = 0;
	initial
	begin
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	sar_ctl #(.HALF_CYC(2), .CAL_HALVES(40)) dut (.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i), .cs_n_i(cs_n), .wr_n_i(wr_n), .rd_n_i(rd_n),
		.sh_n_i(sh_n), .cal_n_i(cal_n), .offset_null_request_n_i(null_n),
		.sample_i(sample), .end_of_conv_o(eoc), .result_ready_n_o(rdy_n),
		.result_byte_bus_o(bus), .result_byte_bus_oe_o(oe),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we),
		.reg_re_i(re), .reg_rdata_o(rdata), .irq_o(irq));
	host_model host (.clk_sys_i(clk_sys_i), .end_of_conv_i(eoc),
		.result_ready_n_i(rdy_n), .result_byte_bus_i(bus),
		.result_byte_bus_oe_i(oe), .cs_n_o(cs_n), .wr_n_o(wr_n),
		.rd_n_o(rd_n), .sh_n_o(sh_n), .cal_n_o(cal_n),
		.offset_null_request_n_o(null_n));
	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clk_sys_i);
		we <= 1'b0;
	endtask
	task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_sys_i);
		addr <= a;
		re <= 1'b1;
		@(posedge clk_sys_i);
		re <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic wait_eoc(input logic lvl, output int n);
		n = 0;
		#1;
		while (eoc !== lvl && n < 2000)
		begin
			@(posedge clk_sys_i);
			#1 n++;
		end
	endtask
	task automatic finish_conv(input sample_t s);
		int n;
		logic [7:0] b;
		logic o, r;
		wait_eoc(1'b1, n);
		`CHK("conv_len", 1'b1, n >= 50 && n <= 56)
		@(posedge clk_sys_i);
		#1 `CHK("ready_n", 1'b0, rdy_n)
		`CHK("irq", 1'b1, irq)
		host.read_byte(1'b0, b, o, r);
		`CHK("upper", {{4{s[12]}}, s[11:8]}, b)
		`CHK("oe", 1'b1, o)
		`CHK("ready_rd", 1'b1, r)
		host.read_byte(1'b0, b, o, r);
		`CHK("lower", s[7:0], b)
		reg_wr(`REG_CLEAR, 8'h01);
		@(posedge clk_sys_i);
		#1 `CHK("irq_clr", 1'b0, irq)
	endtask
	task automatic t_regs();
		logic [7:0] d;
		`CHK("rst_eoc", 1'b1, eoc)
		`CHK("rst_rdy", 1'b1, rdy_n)
		`CHK("rst_oe", 1'b0, oe)
		reg_rd(`REG_ENABLE, d);
		`CHK("en_rst", 8'h00, d)
		reg_wr(`REG_ENABLE, 8'h03);
		reg_wr(`REG_STATUS, 8'hFF);
		reg_rd(`REG_ENABLE, d);
		`CHK("en_rw", 8'h03, d)
		reg_rd(`REG_STATUS, d);
		`CHK("status_ro", 8'h00, d)
		reg_rd(4'h2, d);
		`CHK("unmapped", 8'h00, d)
		$display("test regs done");
	endtask
	task automatic t_cal();
		int n;
		logic [7:0] d;
		sample = '0;
		host.calibrate();
		@(posedge clk_sys_i);
		#1 `CHK("cal_eoc", 1'b0, eoc)
		wait_eoc(1'b1, n);
		`CHK("cal_len", 1'b1, n >= CALC - 4 && n <= CALC + 2)
		reg_rd(`REG_STATUS, d);
		`CHK("cal_done", 8'h02, d)
		`CHK("cal_irq", 1'b1, irq)
		reg_wr(`REG_CLEAR, 8'h02);
		@(posedge clk_sys_i);
		#1 `CHK("cal_clr", 1'b0, irq)
		$display("test cal done");
	endtask
	task automatic t_write(input logic nl, input int extra);
		int n;
		sample = 13'h1A5C;
		host.start_write(nl, 1'b0);
		wait_eoc(1'b0, n);
		`CHK("acq", 1'b1, n >= 24 + extra && n <= 27 + extra)
		finish_conv(sample);
		$display("test write done");
	endtask
	task automatic t_sh();
		sample = 13'h05A3;
		host.start_sh();
		#1 `CHK("sh_eoc", 1'b0, eoc)
		finish_conv(sample);
		$display("test sh done");
	endtask
	task automatic t_restart();
		int n;
		logic [7:0] b;
		logic o, r;
		for (int i = 0; i < 2; i++)
		begin
			host.start_write(1'b1, 1'b0);
			wait_eoc(1'b0, n);
			wait_eoc(1'b1, n);
			if (i == 0)
				host.read_byte(1'b0, b, o, r);
		end
		@(posedge clk_sys_i);
		#1 `CHK("done_rdy", 1'b0, rdy_n)
		host.read_byte(1'b1, b, o, r);
		`CHK("cs_oe", 1'b0, o)
		`CHK("cs_rdy", 1'b0, r)
		host.start_write(1'b1, 1'b1);
		repeat (30) @(posedge clk_sys_i);
		#1 `CHK("cs_wr", 1'b1, eoc)
		sample = 13'h0F0F;
		host.start_write(1'b1, 1'b0);
		@(posedge clk_sys_i);
		#1 `CHK("start_rdy", 1'b1, rdy_n)
		`CHK("start_eoc", 1'b1, eoc)
		wait_eoc(1'b0, n);
		finish_conv(sample);
		$display("test restart done");
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		@(posedge clk_sys_i);
		#1 t_regs();
		t_cal();
		t_write(1'b1, 0);
		t_write(1'b0, `NULL_HALVES * 2);
		t_sh();
		t_restart();
		final_report();
	end
	initial
	begin
		#500000;
		n_mismatch++;
		final_report();
	end
endmodule
